// File: rtl/tws_slave.sv
// Two-wire slave holding the oscillator configuration words
`timescale 1ns/1ps
module tws_slave (
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    input  wire logic        POWER_DOWN,
    output logic      [15:0] FREQ_RATIO_WORD,
    output logic      [15:0] OUTPUT_ROUTING_WORD,
    output logic      [7:0]  LINK_SETUP_WORD,
    output logic      [9:0]  DIVISOR_COUNT,
    output logic             COMMIT_BUSY
);
    import tws_pkg::*;

    // ****************************************
    // State
    // ****************************************
    tws_state_e  state_reg;
    tws_state_e  state_next;
    logic        scl_reg;
    logic        sda_reg;
    logic [7:0]  shift_reg;
    logic [3:0]  bit_reg;
    logic [1:0]  byte_reg;
    logic        rd_reg;
    logic        ackd_reg;
    logic [7:0]  cmd_reg;
    logic [15:0] freq_reg;
    logic [15:0] route_reg;
    logic [7:0]  link_reg;
    logic        dirty_reg;
    logic        commit_pend_reg;
    logic [15:0] nv_cnt_reg;
    logic        nv_busy_reg;
    logic        sda_oe_reg;
    logic        loaded_reg;
    logic [39:0] nv_rd;
    logic        nv_wr;

    // ****************************************
    // Bus condition decode
    // ****************************************
    wire scl_rise  = SCL_IN & ~scl_reg;
    wire scl_fall  = ~SCL_IN & scl_reg;
    wire start_det = scl_reg & SCL_IN & sda_reg & ~SDA_IN;
    wire stop_det  = scl_reg & SCL_IN & ~sda_reg & SDA_IN;
    wire byte_done = (bit_reg == 4'h8);
    wire [7:0] in_byte = shift_reg;
    wire addr_match = (in_byte[7:4] == CTRL_CODE)
                    && (in_byte[3:1] == link_reg[2:0]);
    wire can_prog   = ~POWER_DOWN;
    wire ack_ok     = ~nv_busy_reg;
    wire policy     = link_reg[POLICY_BIT];

    function automatic logic [7:0] read_byte(input logic [7:0] cmd, input logic [1:0] idx,
                                             input logic [15:0] f, input logic [15:0] r,
                                             input logic [7:0] l);
        logic [7:0] b;
        b = 8'h00;
        if (cmd == CMD_FREQ_RATIO) begin
            b = idx[0] ? f[7:0] : f[15:8];
        end else if (cmd == CMD_OUT_ROUTE) begin
            b = idx[0] ? r[7:0] : r[15:8];
        end else if (cmd == CMD_LINK_SETUP) begin
            b = l;
        end
        return b;
    endfunction

    // ****************************************
    // Bit-level state machine
    // ****************************************
    always_comb begin
        state_next = state_reg;
        if (start_det) begin
            state_next = ST_RECV;
        end else if (stop_det) begin
            state_next = ST_IDLE;
        end else begin
            case (state_reg)
                ST_RECV: begin
                    if (scl_fall && byte_done) begin
                        state_next = ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (!ackd_reg) begin
                            state_next = ST_SKIP;
                        end else if (rd_reg) begin
                            state_next = ST_SEND;
                        end else begin
                            state_next = ST_RECV;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall && (bit_reg == 4'h7)) begin
                        state_next = ST_MACK;
                    end
                end
                ST_MACK: begin
                    if (scl_fall) begin
                        state_next = sda_reg ? ST_SKIP : ST_SEND;
                    end
                end
                default: state_next = state_reg;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_reg <= ST_IDLE;
            scl_reg   <= 1'b1;
            sda_reg   <= 1'b1;
        end else begin
            state_reg <= state_next;
            scl_reg   <= SCL_IN;
            sda_reg   <= SDA_IN;
        end
    end

    // ****************************************
    // Shifting, addressing and words
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            shift_reg  <= 8'h00;
            bit_reg    <= 4'h0;
            byte_reg   <= 2'h0;
            rd_reg     <= 1'b0;
            ackd_reg   <= 1'b0;
            cmd_reg    <= 8'h00;
            freq_reg   <= FREQ_RESET;
            route_reg  <= ROUTE_RESET;
            link_reg   <= LINK_RESET;
            dirty_reg  <= 1'b0;
            commit_pend_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            loaded_reg <= 1'b0;
        end else begin
            commit_pend_reg <= 1'b0;
            if (!loaded_reg) begin
                loaded_reg <= 1'b1;
                {freq_reg, route_reg, link_reg} <= nv_rd;
            end
            if (start_det || stop_det) begin
                bit_reg    <= 4'h0;
                sda_oe_reg <= 1'b0;
                if (start_det) begin
                    byte_reg <= 2'h0;
                end
                if (dirty_reg && !policy) begin
                    commit_pend_reg <= 1'b1;
                end
                dirty_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_RECV: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], SDA_IN};
                            bit_reg   <= bit_reg + 4'h1;
                        end
                        if (scl_fall && byte_done) begin
                            bit_reg <= 4'h0;
                            ackd_reg <= 1'b1;
                            sda_oe_reg <= ack_ok;
                            if (byte_reg == 2'h0) begin
                                rd_reg     <= in_byte[0];
                                ackd_reg   <= addr_match;
                                sda_oe_reg <= addr_match && ack_ok;
                                byte_reg   <= 2'h1;
                            end else if (!ack_ok || !can_prog) begin
                                ackd_reg   <= ack_ok;
                                sda_oe_reg <= ack_ok;
                            end else if (byte_reg == 2'h1) begin
                                cmd_reg  <= in_byte;
                                byte_reg <= 2'h2;
                                if (in_byte == CMD_COMMIT && policy) begin
                                    commit_pend_reg <= 1'b1;
                                end
                            end else begin
                                byte_reg <= 2'h3;
                                if (cmd_reg == CMD_FREQ_RATIO) begin
                                    if (byte_reg == 2'h2) begin
                                        freq_reg[15:8] <= in_byte;
                                    end else begin
                                        freq_reg[7:0] <= in_byte & FREQ_WR_MASK[7:0];
                                    end
                                    dirty_reg <= 1'b1;
                                end else if (cmd_reg == CMD_OUT_ROUTE) begin
                                    if (byte_reg == 2'h2) begin
                                        route_reg[15:8] <= in_byte & ROUTE_WR_MASK[15:8];
                                    end else begin
                                        route_reg[7:0] <= in_byte & ROUTE_WR_MASK[7:0];
                                    end
                                    dirty_reg <= 1'b1;
                                end else if (cmd_reg == CMD_LINK_SETUP) begin
                                    link_reg        <= in_byte & LINK_WR_MASK;
                                    commit_pend_reg <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            sda_oe_reg <= 1'b0;
                            if (ackd_reg && rd_reg) begin
                                shift_reg  <= read_byte(cmd_reg, 2'h0, freq_reg,
                                                        route_reg, link_reg);
                                sda_oe_reg <= ~read_byte(cmd_reg, 2'h0, freq_reg,
                                                         route_reg, link_reg) >> 7 == 8'h01;
                                byte_reg   <= 2'h1;
                            end
                        end
                    end
                    ST_SEND: begin
                        if (scl_fall) begin
                            bit_reg <= bit_reg + 4'h1;
                            if (bit_reg == 4'h7) begin
                                sda_oe_reg <= 1'b0;          // Release for master ack
                            end else begin
                                shift_reg  <= {shift_reg[6:0], 1'b0};
                                sda_oe_reg <= ~shift_reg[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_fall) begin
                            bit_reg <= 4'h0;
                            if (!sda_reg) begin
                                shift_reg  <= read_byte(cmd_reg, byte_reg, freq_reg,
                                                        route_reg, link_reg);
                                sda_oe_reg <= ~read_byte(cmd_reg, byte_reg, freq_reg,
                                                         route_reg, link_reg) >> 7 == 8'h01;
                                byte_reg   <= byte_reg + 2'h1;
                            end
                        end
                    end
                    default: sda_oe_reg <= 1'b0;
                endcase
            end
        end
    end

    // ****************************************
    // Nonvolatile commit timing
    // ****************************************
    assign nv_wr = commit_pend_reg && !nv_busy_reg;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            nv_busy_reg <= 1'b0;
            nv_cnt_reg  <= 16'h0000;
        end else if (nv_wr) begin
            nv_busy_reg <= 1'b1;
            nv_cnt_reg  <= 16'(NV_CYCLES - 1);
        end else if (nv_busy_reg) begin
            if (nv_cnt_reg == 16'h0000) begin
                nv_busy_reg <= 1'b0;
            end else begin
                nv_cnt_reg <= nv_cnt_reg - 16'h0001;
            end
        end
    end

    tws_nv_store u_nv (
        .clk     (CORE_CLK),
        .rst_n   (RSTN),
        .wr_en   (nv_wr),
        .wr_data ({freq_reg, route_reg, link_reg}),
        .rd_data (nv_rd)
    );

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            SDA_OUT             <= 1'b0;
            SDA_OE              <= 1'b0;
            FREQ_RATIO_WORD     <= FREQ_RESET;
            OUTPUT_ROUTING_WORD <= ROUTE_RESET;
            LINK_SETUP_WORD     <= LINK_RESET;
            DIVISOR_COUNT       <= 10'h000;
            COMMIT_BUSY         <= 1'b0;
        end else begin
            SDA_OUT             <= 1'b0;
            SDA_OE              <= sda_oe_reg;
            FREQ_RATIO_WORD     <= freq_reg;
            OUTPUT_ROUTING_WORD <= route_reg;
            LINK_SETUP_WORD     <= link_reg;
            DIVISOR_COUNT       <= freq_reg[15:6];
            COMMIT_BUSY         <= nv_busy_reg;
        end
    end
endmodule

// File: rtl/tws_pkg.sv
// Shared constants for the two-wire configuration slave
package tws_pkg;
    // ****************************************
    // Bus framing
    // ****************************************
    localparam logic [3:0] CTRL_CODE      = 4'hb;
    localparam logic [7:0] CMD_FREQ_RATIO = 8'h01;
    localparam logic [7:0] CMD_OUT_ROUTE  = 8'h02;
    localparam logic [7:0] CMD_LINK_SETUP = 8'h0d;
    localparam logic [7:0] CMD_COMMIT     = 8'h3f;
    // ****************************************
    // Word layout and defaults
    // ****************************************
    localparam int         POLICY_BIT     = 3;
    localparam logic [15:0] FREQ_RESET    = 16'h0000;
    localparam logic [15:0] ROUTE_RESET   = 16'h1800;
    localparam logic [7:0]  LINK_RESET    = 8'h00;
    localparam logic [7:0]  LINK_WR_MASK  = 8'h0f;
    localparam logic [15:0] ROUTE_WR_MASK = 16'h7fc0;
    localparam logic [15:0] FREQ_WR_MASK  = 16'hffc0;
    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLK_MHZ       = 50;
    localparam int          NV_WRITE_US   = 10;
    localparam int          NV_CYCLES     = NV_WRITE_US * CLK_MHZ;
    localparam logic [2:0]  SCL_FILTER    = 3'h1;
    // ****************************************
    // Bus states
    // ****************************************
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_RECV  = 6'b000010,
        ST_ACK   = 6'b000100,
        ST_SEND  = 6'b001000,
        ST_MACK  = 6'b010000,
        ST_SKIP  = 6'b100000
    } tws_state_e;
endpackage

// File: rtl/tws_nv_store.sv
// Nonvolatile image of the three configuration words
`timescale 1ns/1ps
module tws_nv_store (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wr_en,
    input  wire logic [39:0] wr_data,
    output logic      [39:0] rd_data
);
    import tws_pkg::*;

    logic [39:0] image_reg;

    // ****************************************
    // Storage and registered read
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            image_reg <= {FREQ_RESET, ROUTE_RESET, LINK_RESET};
            rd_data   <= {FREQ_RESET, ROUTE_RESET, LINK_RESET};
        end else begin
            if (wr_en) begin
                image_reg <= wr_data;
            end
            rd_data <= image_reg;
        end
    end
endmodule

// File: verif/tws_slave_monitor.sv
// Port checker for the two-wire configuration slave
`timescale 1ns/1ps
module tws_slave_monitor
    import tws_pkg::*;
(
    input wire logic        CORE_CLK,
    input wire logic        RSTN,
    input wire logic        SCL_IN,
    input wire logic        SDA_IN,
    input wire logic        SDA_OUT,
    input wire logic        SDA_OE,
    input wire logic        POWER_DOWN,
    input wire logic [15:0] FREQ_RATIO_WORD,
    input wire logic [15:0] OUTPUT_ROUTING_WORD,
    input wire logic [7:0]  LINK_SETUP_WORD,
    input wire logic [9:0]  DIVISOR_COUNT,
    input wire logic        COMMIT_BUSY
);
    // ********
    // Busy length counter
    // ********
    int busy_cnt_reg;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN)
            busy_cnt_reg <= 0;
        else
            busy_cnt_reg <= COMMIT_BUSY ? busy_cnt_reg + 1 : 0;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    // ********
    // Properties
    // ********
    sequence s_scl_drops;
        ##[1:8] !SCL_IN;
    endsequence
    sequence s_freq_settled;
        $stable(FREQ_RATIO_WORD) ##1 $stable(FREQ_RATIO_WORD);
    endsequence
    property p_div;
        s_freq_settled |-> DIVISOR_COUNT == FREQ_RATIO_WORD[15:6];
    endproperty
    property p_ack_hold;
        $rose(SCL_IN) && SDA_OE |-> SDA_OE throughout s_scl_drops;
    endproperty
    property p_oe_rise;
        $rose(SDA_OE) |-> !SCL_IN && !$past(SCL_IN);
    endproperty
    property p_oe_fall;
        $fell(SDA_OE) |-> !SCL_IN && !$past(SCL_IN);
    endproperty
    property p_open_drain;
        SDA_OE |-> SDA_OUT == 1'b0;
    endproperty
    property p_busy_nack;
        COMMIT_BUSY && $past(COMMIT_BUSY) |-> !$rose(SDA_OE);
    endproperty
    property p_busy_len;
        $fell(COMMIT_BUSY) |-> busy_cnt_reg >= NV_CYCLES - 1 && busy_cnt_reg <= NV_CYCLES + 1;
    endproperty
    property p_pd_hold;
        POWER_DOWN && $past(POWER_DOWN) && $past(RSTN, 3) |-> $stable(FREQ_RATIO_WORD)
            && $stable(OUTPUT_ROUTING_WORD) && $stable(LINK_SETUP_WORD);
    endproperty
    property p_link_commit;
        $changed(LINK_SETUP_WORD) && $past(RSTN, 3) |-> ##[0:40] COMMIT_BUSY;
    endproperty
    a_div: assert property (p_div) else $error("divisor count off");
    a_ack_hold: assert property (p_ack_hold) else $error("drive lost in high");
    a_oe_rise: assert property (p_oe_rise) else $error("drive rose with clock high");
    a_oe_fall: assert property (p_oe_fall) else $error("drive fell with clock high");
    a_open_drain: assert property (p_open_drain) else $error("data driven high");
    a_busy_nack: assert property (p_busy_nack) else $error("ack while busy");
    a_busy_len: assert property (p_busy_len) else $error("busy length off");
    a_pd_hold: assert property (p_pd_hold) else $error("word changed in power-down");
    a_link_commit: assert property (p_link_commit) else $error("no commit");
endmodule
bind tws_slave tws_slave_monitor u_monitor (
    .CORE_CLK            (CORE_CLK),
    .RSTN                (RSTN),
    .SCL_IN              (SCL_IN),
    .SDA_IN              (SDA_IN),
    .SDA_OUT             (SDA_OUT),
    .SDA_OE              (SDA_OE),
    .POWER_DOWN          (POWER_DOWN),
    .FREQ_RATIO_WORD     (FREQ_RATIO_WORD),
    .OUTPUT_ROUTING_WORD (OUTPUT_ROUTING_WORD),
    .LINK_SETUP_WORD     (LINK_SETUP_WORD),
    .DIVISOR_COUNT       (DIVISOR_COUNT),
    .COMMIT_BUSY         (COMMIT_BUSY)
);

// File: verif/tws_master_model.sv
// Two-wire bus master model
`timescale 1ns/1ps
module tws_master_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // ********
    // Bus tasks, all moves at the falling core edge
    // ********
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    task start();
        sda_low = 1'b0;
        wait_n(3);
        scl = 1'b1;
        wait_n(4);
        sda_low = 1'b1;
        wait_n(4);
        scl = 1'b0;
        wait_n(2);
    endtask
    task stop();
        sda_low = 1'b1;
        wait_n(3);
        scl = 1'b1;
        wait_n(4);
        sda_low = 1'b0;
        wait_n(4);
    endtask
    task bit_io(input logic b, output logic r);
        sda_low = !b;
        wait_n(3);
        scl = 1'b1;
        wait_n(3);
        r = sda;
        wait_n(1);
        scl = 1'b0;
        wait_n(2);
    endtask
    task xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(m, a);
    endtask
endmodule

// File: verif/tws_slave_tb.sv
// Self-checking bench for the two-wire configuration slave
`timescale 1ns/1ps
module tws_slave_tb;
    import tws_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, pwr_dn = 1'b0;
    logic        scl, sda_low, sda_out, sda_oe, busy, nine;
    logic [15:0] freq, route, exp_f, exp_r;
    logic [7:0]  link, q;
    logic [9:0]  div;
    logic [2:0]  sel = 3'h0;
    logic [15:0] e_q[$], o_q[$];
    int          fail_count = 0, checked = 0, cyc = 0;
    event        seen;
    wire         sda = !(sda_low || (sda_oe && !sda_out));
    tws_slave dut (.CORE_CLK(clk), .RSTN(rst_n), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .POWER_DOWN(pwr_dn), .FREQ_RATIO_WORD(freq),
        .OUTPUT_ROUTING_WORD(route), .LINK_SETUP_WORD(link), .DIVISOR_COUNT(div),
        .COMMIT_BUSY(busy));
    tws_master_model mdl (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    // ********
    // Notes, comparison and closing
    // ********
    initial forever #10 clk = ~clk;
    task post(input logic [15:0] e, input logic [15:0] o);
        e_q.push_back(e);
        o_q.push_back(o);
        ->seen;
    endtask
    task chk(input logic [15:0] e, input logic [15:0] o);
        checked++;
        if (o !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, o, e);
        end
    endtask
    initial forever begin
        @(seen);
        while (e_q.size() > 0)
            chk(e_q.pop_front(), o_q.pop_front());
    end
    task end_of_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            $display("wrong value at %0t: run hung", $time);
            end_of_test();
        end
    end
    // ********
    // Transfers
    // ********
    task send(input logic [7:0] b, input logic e);
        mdl.xfer(b, 1'b1, q, nine);
        post({15'h0, e}, {15'h0, nine});
    endtask
    task probe(input logic [7:0] c, input logic e);
        mdl.start();
        send(c, e);
        mdl.stop();
    endtask
    task wr(input logic [7:0] cmd, input logic [7:0] a, b, c, input int n);
        mdl.start();
        send({CTRL_CODE, sel, 1'b0}, 1'b0);
        send(cmd, 1'b0);
        if (n > 0) send(a, 1'b0);
        if (n > 1) send(b, 1'b0);
        if (n > 2) send(c, 1'b0);
        mdl.stop();
    endtask
    task rd(input logic [7:0] cmd, input logic [15:0] e, input int n);
        mdl.start();
        send({CTRL_CODE, sel, 1'b0}, 1'b0);
        send(cmd, 1'b0);
        mdl.start();
        send({CTRL_CODE, sel, 1'b1}, 1'b0);
        mdl.xfer(8'hff, n == 1, q, nine);
        post({8'h00, e[15:8]}, {8'h00, q});
        if (n > 1) begin
            mdl.xfer(8'hff, 1'b1, q, nine);
            post({8'h00, e[7:0]}, {8'h00, q});
        end
        mdl.wait_n(2);
        post(16'h0001, {15'h0, sda});
        mdl.stop();
    endtask
    task settle(input logic e);
        mdl.wait_n(6);
        post({15'h0, e}, {15'h0, busy});
        for (int i = 0; i < 700 && busy !== 1'b0; i++)
            @(negedge clk);
    endtask
    // ********
    // Main sequence
    // ********
    initial begin
        void'($urandom(79641));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        mdl.wait_n(8);
        post(FREQ_RESET, freq);
        post(ROUTE_RESET, route);
        post({8'h00, LINK_RESET}, {8'h00, link});
        probe(8'ha0, 1'b1);
        probe(8'hb2, 1'b1);
        exp_f = 16'($urandom()) & FREQ_WR_MASK;
        wr(CMD_FREQ_RATIO, exp_f[15:8], 8'($urandom()), exp_f[7:0], 3);
        probe({CTRL_CODE, sel, 1'b0}, 1'b1);
        settle(1'b1);
        post(exp_f, freq);
        post({6'h0, exp_f[15:6]}, {6'h0, div});
        rd(CMD_FREQ_RATIO, exp_f, 2);
        exp_r = 16'($urandom()) & ROUTE_WR_MASK;
        wr(CMD_OUT_ROUTE, exp_r[15:8], exp_r[7:0], 8'h00, 2);
        settle(1'b1);
        rd(CMD_OUT_ROUTE, exp_r, 2);
        wr(CMD_LINK_SETUP, 8'h0d, 8'h00, 8'h00, 1);
        sel = 3'h5;
        settle(1'b1);
        probe(8'hb0, 1'b1);
        rd(CMD_LINK_SETUP, 16'h0d00, 1);
        exp_r = exp_r ^ 16'h0040;
        wr(CMD_OUT_ROUTE, exp_r[15:8], exp_r[7:0], 8'h00, 2);
        settle(1'b0);
        post(exp_r, route);
        wr(CMD_COMMIT, 8'h00, 8'h00, 8'h00, 0);
        settle(1'b1);
        wr(8'h22, 8'h55, 8'h00, 8'h00, 1);
        post(exp_f, freq);
        post(exp_r, route);
        post(16'h000d, {8'h00, link});
        pwr_dn = 1'b1;
        wr(CMD_FREQ_RATIO, ~exp_f[15:8], 8'h00, 8'h00, 1);
        pwr_dn = 1'b0;
        settle(1'b0);
        post(exp_f, freq);
        mdl.wait_n(4);
        end_of_test();
    end
endmodule
